/* hw/lmpc_top.sv */
// Lamp output control: register slave, event stretching, decode, pairing.
// Assumes status inputs come from logic on aclk; the strap pin is asynchronous.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "lmpc_defines.svh"
module lmpc_top #(
  parameter int T32_CYC = int'(64'(`LMPC_T32_MS) * `LMPC_CLK_HZ / 1000),
  parameter int T64_CYC = int'(64'(`LMPC_T64_MS) * `LMPC_CLK_HZ / 1000),
  parameter int T104_CYC = int'(64'(`LMPC_T104_MS) * `LMPC_CLK_HZ / 1000),
  parameter int STEP_CYC = int'(64'(`LMPC_STEP_MS) * `LMPC_CLK_HZ / 1000),
  parameter int BLINK_CYC = int'(64'(`LMPC_BLINK_MS) * `LMPC_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [`LMPC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`LMPC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line status
  input wire logic link_up,
  input wire logic [1:0] speed,
  input wire logic full_duplex,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic collision,
  // Strap pin
  input wire logic lamp_config_strap,
  // Lamp outputs
  output logic lamp_low_speed,
  output logic lamp_mid_speed,
  output logic lamp_high_speed,
  output logic lamp_link_activity
);
  lmpc_pkg::lmpc_state_t s_q;
  lmpc_pkg::lmpc_state_t s_d;
  logic [2:0] ev;
  logic [2:0] str;
  logic [3:0] raw;
  logic [3:0] outv;
  logic sp10;
  logic sp100;
  logic sp1000;
  logic act;
  logic [`LMPC_CW-1:0] len;
  logic [15:0] rd_val;
  logic rd_hit;
  localparam logic [15:0] CTRL_WMASK = `LMPC_CTRL_WMASK;

  assign ev = {collision, rx_active, tx_active};
  assign sp10 = link_up && (speed == `LMPC_SPD_10);
  assign sp100 = link_up && (speed == `LMPC_SPD_100);
  assign sp1000 = link_up && (speed == `LMPC_SPD_1000);
  assign act = str[0] | str[1];

  // Stretch length from the duration field
  always_comb begin
    case (s_q.ctrl[`LMPC_BIT_DUR_HI:`LMPC_BIT_DUR_LO])
      2'h0: len = `LMPC_CW'(T32_CYC);
      2'h1: len = `LMPC_CW'(T64_CYC);
      2'h2: len = `LMPC_CW'(T104_CYC);
      default: len = `LMPC_CW'(int'(s_q.xstr) * STEP_CYC);
    endcase
  end

  // Stretched events
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      str[i] = ev[i] | (s_q.ctrl[`LMPC_BIT_STR_EN] && (s_q.scnt[i] != '0));
    end
  end

  function automatic logic decode(input logic [3:0] c, input logic ext);
    logic r;
    r = 1'b0;
    if (!ext) begin
      case (c)
        4'h0: r = sp1000;
        4'h1: r = sp100;
        4'h2: r = sp10;
        4'h3: r = sp1000 | (sp100 & s_q.blink);
        4'h4: r = link_up;
        4'h5: r = str[0];
        4'h6: r = str[1];
        4'h7: r = act;
        4'h8: r = full_duplex;
        4'h9: r = str[2];
        4'ha: r = link_up & (!act | s_q.blink);
        4'hb: r = link_up & (!str[1] | s_q.blink);
        4'hc: r = full_duplex & (!str[1] | s_q.blink);
        4'hd: r = s_q.blink;
        `LMPC_CODE_ON: r = 1'b1;
        `LMPC_CODE_OFF: r = 1'b0;
        default: r = 1'b0;
      endcase
    end else begin
      case (c)
        4'h0: r = sp10 | sp100;
        4'h1: r = sp100 | sp1000;
        4'h2: r = sp10 | sp1000;
        4'h3: r = sp100 & (!act | s_q.blink);
        4'h4: r = (sp10 | sp100) & (!act | s_q.blink);
        4'h5: r = (sp100 | sp1000) & (!act | s_q.blink);
        default: r = 1'b0;
      endcase
    end
    return r;
  endfunction

  // Lamp index 0 low, 1 mid, 2 high, 3 link
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      raw[i] = decode(s_q.func[(3-i)*4 +: 4], s_q.ctrl[`LMPC_BIT_EXT_LOW-i]);
    end
    outv[1] = raw[1];
    outv[0] = raw[0] & !(s_q.ctrl[`LMPC_BIT_PAIR_ML] & raw[1]);
    outv[3] = raw[3];
    outv[2] = raw[2] & !(s_q.ctrl[`LMPC_BIT_PAIR_LH] & raw[3]);
  end

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[`LMPC_AW-1:2])
      `LMPC_IDX_CTRL: rd_val = s_q.ctrl & `LMPC_CTRL_WMASK;
      `LMPC_IDX_FUNC: rd_val = s_q.func;
      `LMPC_IDX_XSTR: rd_val = {7'h00, s_q.xstr};
      `LMPC_IDX_STAT: rd_val = {4'h0, s_q.lamps, 4'h0, s_q.blink, str};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    // Write channel capture
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.awv = 1'b1;
      s_d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.wv = 1'b1;
      s_d.wd = s_axi_wdata[15:0];
      s_d.ws = s_axi_wstrb[1:0];
    end
    if (s_q.awv && s_q.wv && !s_q.bvalid) begin
      s_d.awv = 1'b0;
      s_d.wv = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `LMPC_RESP_OKAY;
      case (s_q.awa[`LMPC_AW-1:2])
        `LMPC_IDX_CTRL: begin
          for (int b = 0; b < 2; b++) begin
            if (s_q.ws[b]) begin
              s_d.ctrl[b*8 +: 8] = s_q.wd[b*8 +: 8] & CTRL_WMASK[b*8 +: 8];
            end
          end
        end
        `LMPC_IDX_FUNC: begin
          for (int b = 0; b < 2; b++) begin
            if (s_q.ws[b]) begin
              s_d.func[b*8 +: 8] = s_q.wd[b*8 +: 8];
            end
          end
        end
        `LMPC_IDX_XSTR: begin
          if (s_q.ws[0]) begin
            s_d.xstr[7:0] = s_q.wd[7:0];
          end
          if (s_q.ws[1]) begin
            s_d.xstr[8] = s_q.wd[8];
          end
        end
        `LMPC_IDX_STAT: ;
        default: s_d.bresp = `LMPC_RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_val;
      s_d.rresp = rd_hit ? `LMPC_RESP_OKAY : `LMPC_RESP_SLVERR;
    end
    // Strap capture after release
    s_d.sync1 = lamp_config_strap;
    s_d.sync2 = s_q.sync1;
    case (s_q.sp)
      lmpc_pkg::SP_W0: s_d.sp = lmpc_pkg::SP_W1;
      lmpc_pkg::SP_W1: s_d.sp = lmpc_pkg::SP_W2;
      lmpc_pkg::SP_W2: begin
        s_d.sp = lmpc_pkg::SP_DONE;
        s_d.ctrl[`LMPC_BIT_EXT_LOW] = s_q.sync2;
        s_d.ctrl[`LMPC_BIT_DIS] = s_q.sync2;
      end
      default: s_d.sp = lmpc_pkg::SP_DONE;
    endcase
    // Event stretch counters
    for (int i = 0; i < 3; i++) begin
      if (ev[i]) begin
        s_d.scnt[i] = len;
      end else if (s_q.scnt[i] != '0) begin
        s_d.scnt[i] = s_q.scnt[i] - `LMPC_CW'(1);
      end
    end
    // Blink timebase
    if (s_q.bcnt >= `LMPC_CW'(BLINK_CYC - 1)) begin
      s_d.bcnt = '0;
      s_d.blink = !s_q.blink;
    end else begin
      s_d.bcnt = s_q.bcnt + `LMPC_CW'(1);
    end
    // Output stage
    s_d.lamps = s_q.ctrl[`LMPC_BIT_DIS] ? 4'h0 : outv;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl <= `LMPC_CTRL_RST;
      s_q.func <= `LMPC_FUNC_RST;
      s_q.xstr <= `LMPC_XSTR_RST;
      s_q.sp <= lmpc_pkg::SP_W0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.awv && !s_q.bvalid;
  assign s_axi_wready = !s_q.wv && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = {16'h0000, s_q.rdata};
  assign lamp_low_speed = s_q.lamps[0];
  assign lamp_mid_speed = s_q.lamps[1];
  assign lamp_high_speed = s_q.lamps[2];
  assign lamp_link_activity = s_q.lamps[3];

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_strap_load;
    (s_q.sp == lmpc_pkg::SP_W2) ##1 (s_q.sp == lmpc_pkg::SP_DONE);
  endsequence
  property p_pair_ml;
    $past(s_q.ctrl[`LMPC_BIT_PAIR_ML]) |-> !(lamp_mid_speed && lamp_low_speed);
  endproperty
  a_pair_ml: assert property (p_pair_ml) else $error("mid and low lamps both on");
  property p_pair_lh;
    $past(s_q.ctrl[`LMPC_BIT_PAIR_LH]) |-> !(lamp_link_activity && lamp_high_speed);
  endproperty
  a_pair_lh: assert property (p_pair_lh) else $error("link and high lamps both on");
  property p_indep_low;
    $past(aresetn && !s_q.ctrl[`LMPC_BIT_PAIR_ML] && !s_q.ctrl[`LMPC_BIT_DIS]) |->
      lamp_low_speed == $past(raw[0]);
  endproperty
  a_indep_low: assert property (p_indep_low) else $error("low lamp not independent");
  property p_ext_on;
    $past(aresetn && s_q.func[15:12] == `LMPC_CODE_ON && !s_q.ctrl[`LMPC_BIT_DIS] &&
      !s_q.ctrl[`LMPC_BIT_PAIR_ML]) |->
      lamp_low_speed == $past(!s_q.ctrl[`LMPC_BIT_EXT_LOW]);
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("low lamp decode table wrong");
  property p_strap;
    s_strap_load |-> s_q.ctrl[`LMPC_BIT_EXT_LOW] == $past(s_q.sync2) &&
      s_q.ctrl[`LMPC_BIT_DIS] == $past(s_q.sync2);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not loaded");
  property p_dur32;
    ev[0] && s_q.ctrl[3:2] == 2'h0 |=> s_q.scnt[0] == `LMPC_CW'(T32_CYC);
  endproperty
  a_dur32: assert property (p_dur32) else $error("stretch count not 32 ms");
  property p_prog;
    ev[1] && s_q.ctrl[3:2] == `LMPC_DUR_PROG |=>
      s_q.scnt[1] == `LMPC_CW'(int'($past(s_q.xstr)) * STEP_CYC);
  endproperty
  a_prog: assert property (p_prog) else $error("programmed stretch wrong");
  property p_dis;
    $past(s_q.ctrl[`LMPC_BIT_DIS]) |-> s_q.lamps == 4'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("lamps lit while disabled");
  property p_nostr;
    !s_q.ctrl[`LMPC_BIT_STR_EN] |-> str == ev;
  endproperty
  a_nostr: assert property (p_nostr) else $error("stretch while disabled");
  property p_res;
    s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[`LMPC_AW-1:2] == `LMPC_IDX_CTRL) |-> s_axi_rdata[9:8] == 2'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits not zero");
endmodule
`default_nettype wire

/* hw/lmpc_defines.svh */
// Constants of the lamp output control block.
// Assumes a 25 MHz device clock and word-aligned AXI4-Lite access.
`ifndef LMPC_DEFINES_SVH
`define LMPC_DEFINES_SVH
`define LMPC_CLK_HZ 25000000
`define LMPC_AW 10
`define LMPC_IDX_CTRL 8'h1b
`define LMPC_IDX_FUNC 8'h1c
`define LMPC_IDX_XSTR 8'h1e
`define LMPC_IDX_STAT 8'h1f
`define LMPC_BIT_PAIR_ML 15
`define LMPC_BIT_PAIR_LH 14
`define LMPC_BIT_EXT_LOW 13
`define LMPC_BIT_DUR_HI 3
`define LMPC_BIT_DUR_LO 2
`define LMPC_BIT_DIS 1
`define LMPC_BIT_STR_EN 0
`define LMPC_CTRL_WMASK 16'hfc0f
`define LMPC_CTRL_RST 16'h0001
`define LMPC_FUNC_RST 16'h210a
`define LMPC_XSTR_RST 9'h000
`define LMPC_T32_MS 32
`define LMPC_T64_MS 64
`define LMPC_T104_MS 104
`define LMPC_STEP_MS 4
`define LMPC_BLINK_MS 100
`define LMPC_CODE_ON 4'he
`define LMPC_CODE_OFF 4'hf
`define LMPC_DUR_PROG 2'h3
`define LMPC_SPD_10 2'h0
`define LMPC_SPD_100 2'h1
`define LMPC_SPD_1000 2'h2
`define LMPC_RESP_OKAY 2'h0
`define LMPC_RESP_SLVERR 2'h2
`define LMPC_CW 26
`endif

/* hw/lmpc_pkg.sv */
// Types of the lamp output control block.
// Assumes lmpc_defines.svh on the include path.
`include "lmpc_defines.svh"
package lmpc_pkg;
  typedef enum logic [1:0] {
    SP_W0 = 2'b00,
    SP_W1 = 2'b01,
    SP_W2 = 2'b10,
    SP_DONE = 2'b11
  } lmpc_strap_t;

  typedef struct packed {
    logic awv;
    logic [`LMPC_AW-1:0] awa;
    logic wv;
    logic [15:0] wd;
    logic [1:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic [15:0] ctrl;
    logic [15:0] func;
    logic [8:0] xstr;
    logic [2:0][`LMPC_CW-1:0] scnt;
    logic [`LMPC_CW-1:0] bcnt;
    logic blink;
    logic sync1;
    logic sync2;
    lmpc_strap_t sp;
    logic [3:0] lamps;
  } lmpc_state_t;
endpackage

/* bench/lmpc_top_tb_top.sv */
// Self-checking bench of the lamp output control block.
// Assumes lmpc_top with shortened stretch counts, driven over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "lmpc_defines.svh"
`define CHK(a, b) begin \
  n_tests++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); \
  end \
end
module lmpc_top_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic link_up = 1'b1, full_duplex = 1'b0, tx_active = 1'b0, rx_active = 1'b0;
  logic collision = 1'b0, lamp_config_strap = 1'b0;
  logic [1:0] speed = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire l_low, l_mid, l_high, l_link;
  wire [3:0] lamps = {l_link, l_high, l_mid, l_low};
  int errors = 0;
  int n_tests = 0;
  logic [35:0] tbl [14] = '{
    {16'h0001, 16'h4210, 4'h3}, {16'h3c01, 16'h1245, 4'h6}, {16'h0001, 16'h87a3, 4'h4},
    {16'h0001, 16'heeee, 4'hf}, {16'h8001, 16'heeee, 4'he}, {16'h4001, 16'heeee, 4'hb},
    {16'hc001, 16'heeee, 4'ha}, {16'hc001, 16'heffe, 4'h9}, {16'h0003, 16'heeee, 4'h0},
    {16'h0001, 16'hffff, 4'h0}, {16'h2001, 16'h0fff, 4'h1}, {16'h0001, 16'h0fff, 4'h0},
    {16'h1001, 16'hf0ff, 4'h2}, {16'h0c01, 16'hff00, 4'hc}};
  logic [3:0] ev_code [3] = '{4'h5, 4'h6, 4'h9};
  logic [1:0] rsp;
  logic [31:0] rd;
  int n;
  int st;
  int e;

  always #20 aclk = ~aclk;

  lmpc_top #(.T32_CYC(32), .T64_CYC(64), .T104_CYC(104), .STEP_CYC(4), .BLINK_CYC(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .link_up(link_up), .speed(speed), .full_duplex(full_duplex), .tx_active(tx_active),
    .rx_active(rx_active), .collision(collision), .lamp_config_strap(lamp_config_strap),
    .lamp_low_speed(l_low), .lamp_mid_speed(l_mid), .lamp_high_speed(l_high),
    .lamp_link_activity(l_link));

  task automatic wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One event cycle on source k, then count cycles the link lamp is lit
  task automatic pulse(input int k, output int cnt);
    @(posedge aclk);
    {collision, rx_active, tx_active} <= 3'b001 << k;
    @(posedge aclk);
    {collision, rx_active, tx_active} <= 3'b000;
    cnt = 0;
    repeat (150) begin
      @(posedge aclk);
      if (l_link === 1'b1) cnt++;
    end
  endtask

  function automatic int exp_len(input int dur, input int steps);
    case (dur)
      0: return 32;
      1: return 64;
      2: return 104;
      3: return steps * 4;
      default: return 1;
    endcase
  endfunction

  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (12000) @(posedge aclk);
    errors++;
    close_out();
  end

  initial begin
    void'($urandom(56127));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rdr(`LMPC_IDX_CTRL, rd, rsp);
    `CHK(rd, 32'h0001)
    rdr(`LMPC_IDX_FUNC, rd, rsp);
    `CHK(rd, 32'h210a)
    wr(`LMPC_IDX_CTRL, 16'hffff, rsp);
    `CHK(rsp, 2'h0)
    rdr(`LMPC_IDX_CTRL, rd, rsp);
    `CHK(rd, 32'hfc0f)
    wr(8'h05, 16'h1234, rsp);
    `CHK(rsp, 2'h2)
    rdr(8'h05, rd, rsp);
    `CHK({rsp, rd}, {2'h2, 32'h0})
    repeat (4) begin
      e = $urandom_range(0, 16'hffff);
      wr(`LMPC_IDX_FUNC, 16'(e), rsp);
      rdr(`LMPC_IDX_FUNC, rd, rsp);
      `CHK(rd, 32'(e))
    end
    foreach (tbl[i]) begin
      wr(`LMPC_IDX_FUNC, tbl[i][19:4], rsp);
      wr(`LMPC_IDX_CTRL, tbl[i][35:20], rsp);
      repeat (3) @(posedge aclk);
      `CHK(lamps, tbl[i][3:0])
    end
    for (int k = 0; k < 3; k++) begin
      wr(`LMPC_IDX_FUNC, {12'hfff, ev_code[k]}, rsp);
      for (int d = 0; d < 5; d++) begin
        st = $urandom_range(0, 8);
        wr(`LMPC_IDX_XSTR, 16'(st), rsp);
        wr(`LMPC_IDX_CTRL, (d < 4) ? 16'(d * 4 + 1) : 16'h0000, rsp);
        pulse(k, n);
        e = exp_len(d, st);
        `CHK(n >= e - 1 && n <= e + 3, 1'b1)
      end
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    lamp_config_strap <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(`LMPC_IDX_FUNC, 16'heeee, rsp);
    rdr(`LMPC_IDX_CTRL, rd, rsp);
    `CHK(rd, 32'h2003)
    repeat (3) @(posedge aclk);
    `CHK(lamps, 4'h0)
    close_out();
  end
endmodule
`default_nettype wire
